// ### design/ssf_dev_end.sv
// Memory-side front end of the serial link: deserialiser, serialiser, pause and mode control
module ssf_dev_end (
    ssf_link_if.dev                        link,          // Serial link pins
    input  wire logic                      i_clock,       // System clock
    input  wire logic                      i_rst,         // Synchronous reset
    input  wire logic                      i_write_busy,  // Internal write cycle running
    output logic                           o_standby,     // Device in standby
    output logic                           o_rx_valid,    // Received byte present
    output logic [ssf_pkg::DATA_W-1:0]     o_rx_data,     // Received byte
    output logic                           o_rx_first,    // Byte is the instruction
    input  wire logic                      i_rx_ready,    // Received byte taken
    output logic [ssf_pkg::ADDR_W-1:0]     o_addr,        // Start address of frame
    output logic                           o_addr_valid,  // Pulse: address complete
    input  wire logic                      i_tx_valid,    // Read byte offered
    input  wire logic [ssf_pkg::DATA_W-1:0] i_tx_data,    // Read byte
    output logic                           o_tx_ready,    // Read byte slot free
    output ssf_pkg::ssf_mode_t             o_mode,        // Active bus width
    output logic                           o_paused       // Transfer suspended
);
    import ssf_pkg::*;

    logic [5:0]        pin_s1;
    logic [5:0]        pin_s2;
    logic              sck_d;
    ssf_mode_t         mode;
    ssf_mode_t         pending_mode;
    logic [7:0]        in_shift;
    logic [3:0]        in_cnt;
    logic [2:0]        byte_idx;
    logic [15:0]       addr_acc;
    logic [7:0]        out_shift;
    logic [3:0]        out_left;
    logic              tx_active;
    logic [7:0]        tx_hold;
    logic              tx_hold_full;
    logic              paused;
    logic [3:0]        io_out;
    logic [3:0]        io_oe;
    logic              fifo_in_ready;

    // Pin synchronisers: only the second stage is read
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pin_s1 <= PIN_RESET;
            pin_s2 <= PIN_RESET;
            sck_d  <= 1'b1;
        end else begin
            pin_s1 <= {link.cs_n, link.sck, link.io};
            pin_s2 <= pin_s1;
            sck_d  <= pin_s2[4];
        end
    end

    wire       cs_high   = pin_s2[5];
    wire       sck_lvl   = pin_s2[4];
    wire [3:0] io_in     = pin_s2[3:0];
    wire [3:0] lanes     = ssf_lanes(mode);
    wire       hold_low  = (mode != MODE_QUAD) & ~io_in[3];
    wire       rise      = sck_lvl & ~sck_d;
    wire       fall      = ~sck_lvl & sck_d;
    wire       started   = (byte_idx != 3'h0) | (in_cnt != 4'h0) | tx_active;
    wire       byte_done = (in_cnt + lanes) == 4'h8;

    // MSB first: new bits enter at the bottom
    wire [7:0] next_in = (mode == MODE_QUAD) ? {in_shift[3:0], io_in}
                       : (mode == MODE_DUAL) ? {in_shift[5:0], io_in[1:0]}
                       : {in_shift[6:0], io_in[0]};
    wire       first_byte = (byte_idx == 3'h0);
    wire       is_mode_cmd = (next_in == OP_ENTER_FOUR) | (next_in == OP_ENTER_TWO) | (next_in == OP_RETURN_ONE);

    // Edges count only while selected, unpaused and not held; a full FIFO stalls capture
    wire rise_ok = rise & ~cs_high & ~paused & ~hold_low & ~tx_active
                 & (~byte_done | fifo_in_ready);
    wire fall_ok = fall & ~cs_high & ~paused & ~hold_low;
    wire push    = rise_ok & byte_done & ~(first_byte & is_mode_cmd);

    wire pause_start = ~cs_high & started & hold_low & ~sck_lvl;
    wire pause_end   = paused & ~hold_low & ~sck_lvl;

    wire [3:0] lane_mask = (mode == MODE_QUAD) ? 4'hf
                         : (mode == MODE_DUAL) ? 4'h3
                         : 4'h2;
    wire [3:0] out_bits  = (mode == MODE_QUAD) ? out_shift[7:4]
                         : (mode == MODE_DUAL) ? {2'b00, out_shift[7:6]}
                         : {2'b00, out_shift[7], 1'b0};
    wire       drive     = tx_active & ~cs_high & ~paused & ~hold_low;
    wire       hold_take = i_tx_valid & o_tx_ready;
    wire       load_out  = fall_ok & (~tx_active | (out_left <= lanes)) & tx_hold_full;
    wire       next_hold_full = (tx_hold_full & ~load_out) | hold_take;

    ssf_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .i_clock     (i_clock),
        .i_rst       (i_rst),
        .i_in_valid  (push),
        .i_in_data   ({first_byte, next_in}),
        .o_in_ready  (fifo_in_ready),
        .o_out_valid (o_rx_valid),
        .o_out_data  ({o_rx_first, o_rx_data}),
        .i_out_ready (i_rx_ready)
    );

    // Receive side and mode control
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            mode         <= MODE_SINGLE;
            pending_mode <= MODE_SINGLE;
            in_shift     <= 8'h00;
            in_cnt       <= 4'h0;
            byte_idx     <= 3'h0;
            addr_acc     <= 16'h0000;
            o_addr       <= '0;
            o_addr_valid <= 1'b0;
            paused       <= 1'b0;
        end else if (cs_high) begin
            mode     <= pending_mode;
            in_cnt   <= 4'h0;
            byte_idx <= 3'h0;
            paused   <= 1'b0;
            o_addr_valid <= 1'b0;
        end else begin
            o_addr_valid <= 1'b0;
            if (pause_start) begin
                paused <= 1'b1;
            end else if (pause_end) begin
                paused <= 1'b0;
            end
            if (rise_ok) begin
                in_shift <= next_in;
                in_cnt   <= byte_done ? 4'h0 : in_cnt + lanes;
            end
            if (rise_ok & byte_done) begin
                byte_idx <= (byte_idx == 3'h4) ? byte_idx : byte_idx + 3'h1;
                if (first_byte & (next_in == OP_ENTER_FOUR)) begin
                    pending_mode <= MODE_QUAD;
                end else if (first_byte & (next_in == OP_ENTER_TWO)) begin
                    pending_mode <= MODE_DUAL;
                end else if (first_byte & (next_in == OP_RETURN_ONE)) begin
                    pending_mode <= MODE_SINGLE;
                end
                if (!first_byte && byte_idx <= 3'(ADDR_BYTES)) begin
                    addr_acc <= {addr_acc[7:0], next_in};
                end
                if (byte_idx == 3'(ADDR_BYTES)) begin
                    o_addr       <= {addr_acc[ADDR_W-9:0], next_in};
                    o_addr_valid <= 1'b1;
                end
            end
        end
    end

    // Transmit side: one holding byte, shifter advanced on falling edges
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            out_shift    <= 8'h00;
            out_left     <= 4'h0;
            tx_active    <= 1'b0;
            tx_hold      <= 8'h00;
            tx_hold_full <= 1'b0;
            o_tx_ready   <= 1'b0;
        end else if (cs_high) begin
            tx_active    <= 1'b0;
            out_left     <= 4'h0;
            tx_hold_full <= 1'b0;
            o_tx_ready   <= 1'b1;
        end else begin
            if (hold_take) begin
                tx_hold <= i_tx_data;
            end
            tx_hold_full <= next_hold_full;
            o_tx_ready   <= ~next_hold_full;
            if (load_out) begin
                out_shift <= tx_hold;
                out_left  <= 4'h8;
                tx_active <= 1'b1;
            end else if (fall_ok & tx_active & (out_left > lanes)) begin
                out_shift <= out_shift << lanes;
                out_left  <= out_left - lanes;
            end else if (fall_ok & tx_active) begin
                tx_active <= 1'b0;
            end
        end
    end

    // Pin and status registers
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            io_out    <= 4'h0;
            io_oe     <= 4'h0;
            o_standby <= 1'b1;
            o_mode    <= MODE_SINGLE;
            o_paused  <= 1'b0;
        end else begin
            io_out    <= out_bits;
            io_oe     <= drive ? lane_mask : 4'h0;
            o_standby <= cs_high & ~i_write_busy;
            o_mode    <= mode;
            o_paused  <= paused;
        end
    end

    assign link.dev_io_out = io_out;
    assign link.dev_io_oe  = io_oe;
endmodule // ssf_dev_end

// ### design/ssf_pkg.sv
// Shared constants and types for the serial memory front end and its host
package ssf_pkg;
    localparam int          DATA_W        = 8;
    localparam int          ADDR_W        = 17;     // 128 K byte locations
    localparam int          MEM_WORDS     = 131072;
    localparam int          ADDR_BYTES    = 3;
    localparam int          LANES         = 4;
    localparam int          FIFO_DEPTH    = 16;
    localparam int          FIFO_W        = DATA_W + 1;
    localparam logic [7:0]  OP_ENTER_FOUR = 8'h38;
    localparam logic [7:0]  OP_ENTER_TWO  = 8'h3b;
    localparam logic [7:0]  OP_RETURN_ONE = 8'hff;
    localparam logic [5:0]  PIN_RESET     = 6'h38;  // cs_n high, clock high, hold high
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          SCK_PERIOD_NS = 160;
    localparam int          SCK_HALF_CYC  = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int          TIMER_W       = 4;

    typedef enum logic [1:0] {MODE_SINGLE, MODE_DUAL, MODE_QUAD} ssf_mode_t;

    // Data lines used per clock in each mode
    function automatic logic [3:0] ssf_lanes(input ssf_mode_t m);
        return (m == MODE_QUAD) ? 4'h4 : (m == MODE_DUAL) ? 4'h2 : 4'h1;
    endfunction
endpackage

// ### design/ssf_link_if.sv
// Serial link between host and memory front end, with pull-up resolution of the data lines
interface ssf_link_if;
    logic       cs_n;
    logic       sck;
    logic [3:0] host_io_out;
    logic [3:0] host_io_oe;
    logic [3:0] dev_io_out;
    logic [3:0] dev_io_oe;
    logic [3:0] io;

    // Device drive wins, then host drive, an undriven line floats high
    assign io = (dev_io_oe & dev_io_out) | (~dev_io_oe & host_io_oe & host_io_out) | (~dev_io_oe & ~host_io_oe);

    modport host (output cs_n, output sck, output host_io_out, output host_io_oe, input io);
    modport dev  (input cs_n, input sck, input io, output dev_io_out, output dev_io_oe);
endinterface

// ### design/ssf_fifo.sv
// Byte FIFO with registered output stage
module ssf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clock,     // System clock
    input  wire logic             i_rst,       // Synchronous reset
    input  wire logic             i_in_valid,  // Write request
    input  wire logic [WIDTH-1:0] i_in_data,   // Write data
    output logic                  o_in_ready,  // Room for a word
    output logic                  o_out_valid, // Output word present
    output logic      [WIDTH-1:0] o_out_data,  // Output word
    input  wire logic             i_out_ready  // Consumer takes word
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;

    wire in_fire = i_in_valid & o_in_ready;
    wire load    = (count != '0) & (~o_out_valid | i_out_ready);

    assign o_in_ready = (count != (AW+1)'(DEPTH));

    always_ff @(posedge i_clock) begin
        if (in_fire) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            count       <= '0;
            o_out_valid <= 1'b0;
            o_out_data  <= '0;
        end else begin
            wr_ptr <= in_fire ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= load ? rd_ptr + 1'b1 : rd_ptr;
            count  <= count + (AW+1)'(in_fire) - (AW+1)'(load);
            if (load) begin
                o_out_valid <= 1'b1;
                o_out_data  <= mem[rd_ptr];
            end else if (i_out_ready) begin
                o_out_valid <= 1'b0;
            end
        end
    end
endmodule // ssf_fifo

// ### design/ssf_host_end.sv
// Host-side controller of the serial link: clock divider, byte shifter, pause and mode tracking
module ssf_host_end (
    ssf_link_if.host                        link,          // Serial link pins
    input  wire logic                       i_clock,       // System clock
    input  wire logic                       i_rst,         // Synchronous reset
    input  wire logic                       i_byte_valid,  // Byte request
    input  wire logic [ssf_pkg::DATA_W-1:0] i_byte_data,   // Byte to send
    input  wire logic                       i_byte_read,   // Byte is read from device
    input  wire logic                       i_byte_last,   // End frame after this byte
    output logic                            o_byte_ready,  // Request accepted when valid
    output logic                            o_rx_valid,    // Pulse: read byte done
    output logic [ssf_pkg::DATA_W-1:0]      o_rx_data,     // Read byte
    input  wire logic                       i_pause,       // Request pause (one and two bit)
    output logic                            o_paused,      // Link paused
    output ssf_pkg::ssf_mode_t              o_mode         // Active bus width
);
    import ssf_pkg::*;

    typedef enum logic [2:0] {H_INIT, H_IDLE, H_WAIT, H_LOW, H_HIGH, H_PAUSE, H_END} ssf_hstate_t;

    ssf_hstate_t          state;
    ssf_mode_t            mode;
    logic [TIMER_W-1:0]   timer;
    logic [7:0]           shift;
    logic [7:0]           rx_shift;
    logic [3:0]           left;
    logic                 rd;
    logic                 last;
    logic                 first;
    logic [7:0]           opcode;
    logic                 cs_n;
    logic                 sck;
    logic [3:0]           io_out;
    logic [3:0]           io_oe;
    logic [3:0]           io_s1;
    logic [3:0]           io_s2;

    localparam logic [TIMER_W-1:0] HALF = TIMER_W'(SCK_HALF_CYC - 1);

    wire       tick      = (timer == '0);
    wire [3:0] lanes     = ssf_lanes(mode);
    wire       accept    = i_byte_valid & o_byte_ready;
    wire       can_pause = (mode != MODE_QUAD) & i_pause;
    wire [7:0] next_rx   = (mode == MODE_QUAD) ? {rx_shift[3:0], io_s2}
                         : (mode == MODE_DUAL) ? {rx_shift[5:0], io_s2[1:0]}
                         : {rx_shift[6:0], io_s2[1]};
    wire       drive     = ((state == H_LOW) | (state == H_HIGH) | (state == H_PAUSE)) & ~rd;
    wire       hold_n    = (state != H_PAUSE);
    wire [3:0] next_oe   = (mode == MODE_QUAD) ? {4{drive}}
                         : (mode == MODE_DUAL) ? {1'b1, 1'b0, drive, drive}
                         : 4'b1001;
    wire [3:0] next_out  = (mode == MODE_QUAD) ? shift[7:4]
                         : (mode == MODE_DUAL) ? {hold_n, 1'b0, shift[7:6]}
                         : {hold_n, 2'b00, shift[7] & ~rd};
    wire       mode_cmd  = (opcode == OP_ENTER_FOUR) | (opcode == OP_ENTER_TWO) | (opcode == OP_RETURN_ONE);
    wire       ready_st  = (state == H_IDLE) | (state == H_WAIT);

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            io_s1 <= 4'hf;
            io_s2 <= 4'hf;
        end else begin
            io_s1 <= link.io;
            io_s2 <= io_s1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state      <= H_INIT;
            mode       <= MODE_SINGLE;
            timer      <= HALF;
            shift      <= 8'h00;
            rx_shift   <= 8'h00;
            left       <= 4'h0;
            rd         <= 1'b0;
            last       <= 1'b0;
            first      <= 1'b1;
            opcode     <= 8'h00;
            cs_n       <= 1'b0;
            sck        <= 1'b0;
            o_rx_valid <= 1'b0;
            o_rx_data  <= 8'h00;
        end else begin
            o_rx_valid <= 1'b0;
            timer      <= tick ? '0 : timer - 1'b1;
            case (state)
                H_INIT: begin
                    if (tick) begin
                        cs_n  <= 1'b1;
                        timer <= HALF;
                        state <= H_END;
                    end
                end
                H_IDLE, H_WAIT: begin
                    if (accept) begin
                        cs_n  <= 1'b0;
                        shift <= i_byte_data;
                        rd    <= i_byte_read;
                        last  <= i_byte_last;
                        left  <= 4'h8;
                        timer <= HALF;
                        state <= H_LOW;
                        if (state == H_IDLE) begin
                            opcode <= i_byte_data;
                            first  <= 1'b1;
                        end else begin
                            first  <= 1'b0;
                        end
                    end
                end
                H_LOW: begin
                    if (can_pause) begin
                        state <= H_PAUSE;
                    end else if (tick) begin
                        sck   <= 1'b1;
                        timer <= HALF;
                        state <= H_HIGH;
                    end
                end
                H_PAUSE: begin
                    if (!i_pause) begin
                        timer <= HALF;
                        state <= H_LOW;
                    end
                end
                H_HIGH: begin
                    if (tick) begin
                        sck      <= 1'b0;
                        rx_shift <= next_rx;
                        timer    <= HALF;
                        if (left > lanes) begin
                            shift <= shift << lanes;
                            left  <= left - lanes;
                            state <= H_LOW;
                        end else begin
                            o_rx_valid <= rd;
                            o_rx_data  <= next_rx;
                            rd         <= 1'b0;
                            if (last) begin
                                cs_n  <= 1'b1;
                                state <= H_END;
                                if (first & mode_cmd) begin
                                    mode <= (opcode == OP_ENTER_FOUR) ? MODE_QUAD
                                          : (opcode == OP_ENTER_TWO) ? MODE_DUAL
                                          : MODE_SINGLE;
                                end
                            end else begin
                                state <= H_WAIT;
                            end
                        end
                    end
                end
                H_END: begin
                    if (tick) begin
                        state <= H_IDLE;
                    end
                end
                default: begin
                    state <= H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            io_out       <= 4'h9;
            io_oe        <= 4'h9;
            o_byte_ready <= 1'b0;
            o_paused     <= 1'b0;
            o_mode       <= MODE_SINGLE;
        end else begin
            io_out       <= next_out;
            io_oe        <= next_oe;
            o_byte_ready <= ready_st & ~accept;
            o_paused     <= (state == H_PAUSE);
            o_mode       <= mode;
        end
    end

    assign link.cs_n        = cs_n;
    assign link.sck         = sck;
    assign link.host_io_out = io_out;
    assign link.host_io_oe  = io_oe;
endmodule // ssf_host_end

// ### tb/ssf_link_monitor.sv
// Checker for the serial link between the host and device ends
module ssf_link_monitor (
    input wire logic               i_clock,     // Clock
    input wire logic               i_rst,       // Reset
    input wire logic               cs_n,        // Select
    input wire logic               sck,         // Serial clock
    input wire logic [3:0]         host_io_out, // Host data
    input wire logic [3:0]         host_io_oe,  // Host enable
    input wire logic [3:0]         dev_io_out,  // Device data
    input wire logic [3:0]         dev_io_oe,   // Device enable
    input wire logic [3:0]         io,          // Lines
    input wire ssf_pkg::ssf_mode_t o_mode       // Device mode
);
    import ssf_pkg::*;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    wire logic [3:0] mask = (o_mode == MODE_QUAD) ? 4'hf : (o_mode == MODE_DUAL) ? 4'h3 : 4'h2;
    sequence s_pause; (o_mode != MODE_QUAD && !io[3]) [*6]; endsequence
    property p_sel_pulse; $past(i_rst) |-> !cs_n [*7]; endproperty
    a_sel_pulse: assert property (p_sel_pulse) else $error("no select pulse");
    property p_idle_off; cs_n [*6] |-> dev_io_oe == 4'h0; endproperty
    a_idle_off: assert property (p_idle_off) else $error("driving while idle");
    property p_out_fall; $changed(dev_io_out & dev_io_oe) |-> !sck; endproperty
    a_out_fall: assert property (p_out_fall) else $error("output moved in high phase");
    property p_in_rise; sck && $past(sck) |-> $stable(host_io_out & host_io_oe); endproperty
    a_in_rise: assert property (p_in_rise) else $error("input moved in high phase");
    property p_lanes; dev_io_oe != 4'h0 |-> dev_io_oe == mask; endproperty
    a_lanes: assert property (p_lanes) else $error("wrong lanes driven");
    property p_pause_off; s_pause |-> dev_io_oe == 4'h0; endproperty
    a_pause_off: assert property (p_pause_off) else $error("driving while paused");
    property p_mode_rst; $past(i_rst) |-> o_mode == MODE_SINGLE; endproperty
    a_mode_rst: assert property (p_mode_rst) else $error("mode not single");
    property p_mode_sel; $changed(o_mode) |-> cs_n; endproperty
    a_mode_sel: assert property (p_mode_sel) else $error("mode moved in frame");
endmodule // ssf_link_monitor

// ### tb/serial_sram_multi_io_front_end_test.sv
// Bench joining host and device ends over the serial link
module serial_sram_multi_io_front_end_test;
    timeunit 1ns;
    timeprecision 1ns;
    import ssf_pkg::*;
    logic i_clock = 0, i_rst = 1, bv = 0, br = 0, bl = 0, hp = 0, wb = 0, tv = 0, rd = 0, rr = 0;
    logic [7:0] bd = 0, td = 8'h3c, sh, h_rd, d_rd, ops[2] = '{8'h3b, 8'h38};
    logic h_rdy, h_rv, h_ps, d_sb, d_rv, d_rf, d_av, d_tr, d_ps;
    logic [16:0] d_addr;
    ssf_mode_t h_mode, d_mode, em[2] = '{MODE_DUAL, MODE_QUAD};
    logic [8:0] q[$];
    int error_cnt = 0, n_tests = 0;
    ssf_link_if link();
    ssf_host_end u_ssf_host_end(.link(link), .i_clock, .i_rst, .i_byte_valid(bv), .i_byte_data(bd), .i_byte_read(br),
        .i_byte_last(bl), .o_byte_ready(h_rdy), .o_rx_valid(h_rv), .o_rx_data(h_rd), .i_pause(hp), .o_paused(h_ps),
        .o_mode(h_mode));
    ssf_dev_end u_ssf_dev_end(.link(link), .i_clock, .i_rst, .i_write_busy(wb), .o_standby(d_sb), .o_rx_valid(d_rv),
        .o_rx_data(d_rd), .o_rx_first(d_rf), .i_rx_ready(rr), .o_addr(d_addr), .o_addr_valid(d_av), .i_tx_valid(tv),
        .i_tx_data(td), .o_tx_ready(d_tr), .o_mode(d_mode), .o_paused(d_ps));
    ssf_link_monitor u_ssf_link_monitor(.i_clock, .i_rst, .cs_n(link.cs_n), .sck(link.sck), .io(link.io),
        .host_io_out(link.host_io_out), .host_io_oe(link.host_io_oe), .dev_io_out(link.dev_io_out),
        .dev_io_oe(link.dev_io_oe), .o_mode(d_mode));
    initial forever #5 i_clock = ~i_clock;
    always @(posedge i_clock) if (d_rv && rr) q.push_back({d_rf, d_rd});
    always @(posedge link.sck) sh <= {sh[6:0], link.io[0]};
    // Offer the read byte once the address is in, withdraw it once taken
    always @(negedge i_clock) tv <= (rd && d_av) ? 1'b1 : (tv && !d_tr) ? 1'b0 : tv;
    task automatic stop_test;
        if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [16:0] g, e);
        n_tests++;
        if (g !== e) error_cnt++;
        if (g !== e) $display("BAD %0t got %h exp %h", $time, g, e);
    endtask
    task automatic wt(input bit s);
        int n = 0;
        while ((s ? h_rv : h_rdy) !== 1'b1 && n < 4000) @(negedge i_clock) n++;
        if (n >= 4000) error_cnt++;
        if (n >= 4000) stop_test;
    endtask
    task automatic frame(input logic [7:0] b[$], input logic r, input int nrx);
        foreach (b[i]) begin
            wt(0);
            {bv, bd, br, bl} = {1'b1, b[i], r && i == b.size() - 1, i == b.size() - 1};
            @(negedge i_clock) bv = 0;
        end
        wt(r);
        if (r) chk(h_rd, 8'h3c);
        wt(0);
        rr = 1;
        repeat (24) @(negedge i_clock);
        for (int i = 0; i < nrx; i++) chk(q.size() ? q.pop_front() : 9'h1ff, {i == 0, b[i]});
        q = {};
    endtask
    initial begin
        repeat (2) @(negedge i_clock);
        i_rst = 0;
        frame({8'h02, 8'h01, 8'h23, 8'h45, 8'ha5}, 0, 5);
        chk(sh, 8'ha5);
        chk(d_addr, 17'h12345);
        rd = 1;
        frame({8'h03, 8'h00, 8'h00, 8'h07, 8'h00}, 1, 4);
        rd = 0;
        foreach (ops[i]) begin
            frame({ops[i]}, 0, 0);
            chk(d_mode, em[i]);
            chk(h_mode, em[i]);
            frame({8'h02, 8'hff, 8'hff, 8'hff, 8'h96}, 0, 5);
            chk(d_addr, 17'h1ffff);
            frame({8'hff}, 0, 0);
            chk(d_mode, MODE_SINGLE);
        end
        fork
            frame({8'h02, 8'h00, 8'h00, 8'h10, 8'h5a}, 0, 5);
            begin
                repeat (300) @(negedge i_clock);
                hp = 1;
                repeat (60) @(negedge i_clock);
                chk(d_ps, 1);
                chk(h_ps, 1);
                chk(link.dev_io_oe, 4'h0);
                chk(d_sb, 0);
                hp = 0;
            end
        join
        wb = 1;
        repeat (6) @(negedge i_clock);
        chk(d_sb, 0);
        wb = 0;
        repeat (6) @(negedge i_clock);
        chk(d_sb, 1);
        stop_test;
    end
endmodule // serial_sram_multi_io_front_end_test
